// >>> tb/tb_digital_clock_rate_config.sv
// bench for the loop feedback and digital generator rate registers
// assumes dcr_pkg and dcr_top are compiled first; one 125 MHz clock
`default_nettype none
module tb_digital_clock_rate_config
  import dcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        mclk, rstn, reg_wr, reg_rd, fb, f1, f2;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [1:0]  c1, c2;
  logic [14:0] k1, k2;
  int          n_fail, check_count;

  dcr_top u_dcr_top (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .second_loop_digital_feedback(fb), .gen_one_family_select(f1),
    .gen_two_family_select(f2), .gen_one_rate_code(c1), .gen_two_rate_code(c2),
    .gen_one_rate_khz(k1), .gen_two_rate_khz(k2));
  // ----------------------------------------------------------------
  // clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    #16000;
    n_fail++;
    stop_test();
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t ns seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one write strobe, returns at the negedge after the capturing edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    check({8'h00, reg_rdata}, {8'h00, exp});
  endtask
  // expected rate table in kHz, family bit 1 is sonet
  function automatic logic [14:0] khz(input logic fam, input logic [1:0] c);
    case ({fam, c})
      3'h0:    khz = 15'h0800; // sdh 2048
      3'h1:    khz = 15'h1000; // sdh 4096
      3'h2:    khz = 15'h2000; // sdh 8192
      3'h3:    khz = 15'h4000; // sdh 16384
      3'h4:    khz = 15'h0608; // sonet 1544
      3'h5:    khz = 15'h0C10; // sonet 3088
      3'h6:    khz = 15'h1820; // sonet 6176
      default: khz = 15'h3040; // sonet 12352
    endcase
  endfunction
  task automatic stop_test();
    if (n_fail == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic       ff;
    logic [1:0] cc;
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    repeat (4) @(negedge mclk);
    rstn = 1'b1;
    // reset values at the pins and through reads
    check({13'h0, f2, f1, fb}, 16'h0001);
    check({12'h000, c2, c1}, 16'h0000);
    check({1'b0, k1}, {1'b0, 15'h0800});
    check({1'b0, k2}, {1'b0, 15'h0800});
    rchk(DCR_OFF_LOOP_FB, 8'h40);
    rchk(DCR_OFF_FAMILY, 8'h14);
    rchk(DCR_OFF_RATE, 8'h08);
    // all ones written: unused bits keep their reset values
    wr(DCR_OFF_LOOP_FB, 8'hFF);
    wr(DCR_OFF_FAMILY, 8'hFF);
    wr(DCR_OFF_RATE, 8'hFF);
    rchk(DCR_OFF_LOOP_FB, 8'h40);
    rchk(DCR_OFF_FAMILY, 8'h74);
    rchk(DCR_OFF_RATE, 8'hF8);
    // feedback bit cleared then set again
    wr(DCR_OFF_LOOP_FB, 8'hBF);
    check({15'h0, fb}, 16'h0000);
    rchk(DCR_OFF_LOOP_FB, 8'h00);
    wr(DCR_OFF_LOOP_FB, 8'h40);
    check({15'h0, fb}, 16'h0001);
    // every family and rate code, generators set differently
    for (int i = 0; i < 8; i++) begin
      ff = i[2];
      cc = i[1:0];
      wr(DCR_OFF_FAMILY, {1'b0, ff, ~ff, 5'h00});
      wr(DCR_OFF_RATE, {cc, ~cc, 4'h0});
      @(negedge mclk);
      check({12'h0, f2, f1, c2}, {12'h0, ff, ~ff, cc});
      check({14'h0, c1}, {14'h0, ~cc});
      check({1'b0, k2}, {1'b0, khz(ff, cc)});
      check({1'b0, k1}, {1'b0, khz(~ff, ~cc)});
    end
    // writes to unmapped neighbours leave the fields alone
    wr(8'h3A, 8'h00);
    wr(8'h36, 8'h00);
    rchk(DCR_OFF_RATE, 8'hC8);
    check({14'h0, c2}, 16'h0003);
    rchk(DCR_OFF_FAMILY, 8'h54);
    rchk(DCR_OFF_LOOP_FB, 8'h40);
    rchk(8'h3A, 8'h00);
    rchk(DCR_OFF_FAMILY, 8'h54);
    // second reset in mid-run restores defaults
    wr(DCR_OFF_LOOP_FB, 8'h00);
    rstn = 1'b0;
    @(negedge mclk);
    rstn = 1'b1;
    check({15'h0, fb}, 16'h0001);
    check({8'h00, reg_rdata}, 16'h0000);
    check({1'b0, k2}, {1'b0, 15'h0800});
    rchk(DCR_OFF_FAMILY, 8'h14);
    rchk(DCR_OFF_RATE, 8'h08);
    stop_test();
  end
endmodule
`default_nettype wire

// >>> verilog/dcr_pkg.sv
// constants for the digital clock rate configuration registers
// assumes one system clock domain and an 8-bit register access port
`default_nettype none
package dcr_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] DCR_OFF_LOOP_FB  = 8'h37;
  localparam logic [7:0] DCR_OFF_FAMILY   = 8'h38;
  localparam logic [7:0] DCR_OFF_RATE     = 8'h39;
  // ----------------------------------------------------------------
  // reset values and meaningful bits
  // ----------------------------------------------------------------
  localparam logic [7:0] DCR_RST_LOOP_FB  = 8'h40;
  localparam logic [7:0] DCR_RST_FAMILY   = 8'h14;
  localparam logic [7:0] DCR_RST_RATE     = 8'h08;
  localparam logic [7:0] DCR_MASK_LOOP_FB = 8'h40;
  localparam logic [7:0] DCR_MASK_FAMILY  = 8'h60;
  localparam logic [7:0] DCR_MASK_RATE    = 8'hF0;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int DCR_POS_FB       = 6;
  localparam int DCR_POS_FAM_TWO  = 6;
  localparam int DCR_POS_FAM_ONE  = 5;
  localparam int DCR_POS_RATE_TWO = 6;
  localparam int DCR_POS_RATE_ONE = 4;
  // ----------------------------------------------------------------
  // rates in kHz, family bit 1 selects sonet
  // ----------------------------------------------------------------
  localparam logic [14:0] DCR_SONET_BASE_KHZ = 15'h0608; // 1544
  localparam logic [14:0] DCR_SDH_BASE_KHZ   = 15'h0800; // 2048
  localparam logic [1:0]  DCR_RATE_X1        = 2'h0;
endpackage
`default_nettype wire

// >>> verilog/dcr_rate_dec.sv
// decodes one generator's family bit and rate code into kHz
// assumes settings come from registers on the same clock
`default_nettype none
module dcr_rate_dec
  import dcr_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rstn,
  dcr_rate_if.dec   rif
);
  logic [14:0] next_rate;
  logic [14:0] rate;

  // base rate shifted by the code
  always_comb begin
    next_rate = (rif.family ? DCR_SONET_BASE_KHZ : DCR_SDH_BASE_KHZ) << rif.code;
  end

  // registered result
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rate <= DCR_SDH_BASE_KHZ;
    end else begin
      rate <= next_rate;
    end
  end

  assign rif.rate_khz = rate;

  rate_follows_code_a: assert property (@(posedge mclk) disable iff (!rstn)
    ##1 rate == (($past(rif.family) ? 15'h0608 : 15'h0800) << $past(rif.code)))
    else $error("rate does not match code");
endmodule
`default_nettype wire

// >>> verilog/dcr_rate_if.sv
// interface carrying one generator's settings to its rate decoder
// assumes both ends sit on the system clock
`default_nettype none
interface dcr_rate_if;
  logic        family;   // 1 sonet, 0 sdh
  logic [1:0]  code;     // multiple of base rate
  logic [14:0] rate_khz; // resulting rate
  modport cfg (output family, output code, input rate_khz);
  modport dec (input family, input code, output rate_khz);
endinterface
`default_nettype wire

// >>> verilog/dcr_top.sv
// register file for loop feedback mode and digital generator rates
// assumes the serial port logic presents single-cycle strobes on mclk
//
// Notes on behaviour
// - bit 6 of the loop feedback register picks analog (0) or digital (1) feedback.
// - the loop feedback register is read/write and resets to 0x40, only bit 6 matters.
// - at 0x38 bit 6 picks sonet or sdh for generator two and bit 5 for generator one.
// - each 2-bit rate code picks one, two, four or eight times the family base rate.
`default_nettype none
module dcr_top
  import dcr_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic             second_loop_digital_feedback,
  output logic             gen_one_family_select,
  output logic             gen_two_family_select,
  output logic      [1:0]  gen_one_rate_code,
  output logic      [1:0]  gen_two_rate_code,
  output logic      [14:0] gen_one_rate_khz,
  output logic      [14:0] gen_two_rate_khz
);
  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [7:0] second_loop_feedback_config;
  logic [7:0] digital_rate_family_select;
  logic [7:0] digital_rate_select;
  logic [7:0] next_loop_fb;
  logic [7:0] next_family;
  logic [7:0] next_rate;
  logic [7:0] next_rdata;

  // keeps used bits of new value, unused bits at reset value
  function automatic logic [7:0] merge(input logic [7:0] val, input logic [7:0] mask,
                                       input logic [7:0] rst);
    merge = (val & mask) | (rst & ~mask);
  endfunction

  // write decode
  always_comb begin
    next_loop_fb = second_loop_feedback_config;
    next_family  = digital_rate_family_select;
    next_rate    = digital_rate_select;
    if (reg_wr) begin
      unique case (reg_addr)
        DCR_OFF_LOOP_FB: next_loop_fb = merge(reg_wdata, DCR_MASK_LOOP_FB,
                                              DCR_RST_LOOP_FB);
        DCR_OFF_FAMILY:  next_family  = merge(reg_wdata, DCR_MASK_FAMILY,
                                              DCR_RST_FAMILY);
        DCR_OFF_RATE:    next_rate    = merge(reg_wdata, DCR_MASK_RATE,
                                              DCR_RST_RATE);
        default: ;
      endcase
    end
  end

  // read mux, unmapped reads zero
  always_comb begin
    next_rdata = reg_rdata;
    if (reg_rd) begin
      unique case (reg_addr)
        DCR_OFF_LOOP_FB: next_rdata = second_loop_feedback_config;
        DCR_OFF_FAMILY:  next_rdata = digital_rate_family_select;
        DCR_OFF_RATE:    next_rdata = digital_rate_select;
        default:         next_rdata = 8'h00;
      endcase
    end
  end

  // register update
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      second_loop_feedback_config <= DCR_RST_LOOP_FB;
      digital_rate_family_select  <= DCR_RST_FAMILY;
      digital_rate_select         <= DCR_RST_RATE;
      reg_rdata                   <= 8'h00;
    end else begin
      second_loop_feedback_config <= next_loop_fb;
      digital_rate_family_select  <= next_family;
      digital_rate_select         <= next_rate;
      reg_rdata                   <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // field outputs
  // ----------------------------------------------------------------
  assign second_loop_digital_feedback = second_loop_feedback_config[DCR_POS_FB];
  assign gen_two_family_select = digital_rate_family_select[DCR_POS_FAM_TWO];
  assign gen_one_family_select = digital_rate_family_select[DCR_POS_FAM_ONE];
  assign gen_two_rate_code = digital_rate_select[DCR_POS_RATE_TWO +: 2];
  assign gen_one_rate_code = digital_rate_select[DCR_POS_RATE_ONE +: 2];

  // ----------------------------------------------------------------
  // rate decoders
  // ----------------------------------------------------------------
  // one interface per generator carries its settings and its rate
  dcr_rate_if one_if ();
  dcr_rate_if two_if ();

  assign one_if.family    = gen_one_family_select;
  assign one_if.code      = gen_one_rate_code;
  assign two_if.family    = gen_two_family_select;
  assign two_if.code      = gen_two_rate_code;
  assign gen_one_rate_khz = one_if.rate_khz;
  assign gen_two_rate_khz = two_if.rate_khz;

  dcr_rate_dec u_dec_one (
    .mclk (mclk),
    .rstn (rstn),
    .rif  (one_if.dec)
  );

  dcr_rate_dec u_dec_two (
    .mclk (mclk),
    .rstn (rstn),
    .rif  (two_if.dec)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // all checks run on mclk and drop out while reset is low
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  fb_write_takes_a: assert property (
    reg_wr && reg_addr == DCR_OFF_LOOP_FB |=> second_loop_digital_feedback == $past(reg_wdata[6]))
    else $error("feedback bit not written");

  fb_readback_a: assert property (
    reg_rd && reg_addr == DCR_OFF_LOOP_FB && !reg_wr |=>
      reg_rdata == {1'b0, second_loop_digital_feedback, 6'h00})
    else $error("feedback register readback wrong");

  family_write_a: assert property (
    reg_wr && reg_addr == DCR_OFF_FAMILY |=>
      gen_two_family_select == $past(reg_wdata[6]) &&
      gen_one_family_select == $past(reg_wdata[5]))
    else $error("family bits not written");

  rate_sdh_top_a: assert property (
    !gen_two_family_select && gen_two_rate_code == 2'h3 && $stable(digital_rate_family_select)
      && $stable(digital_rate_select) |=> gen_two_rate_khz == 15'h4000)
    else $error("sdh top rate wrong");

  unused_bits_a: assert property (
    (digital_rate_family_select & ~DCR_MASK_FAMILY) == (DCR_RST_FAMILY & ~DCR_MASK_FAMILY) &&
    (digital_rate_select & ~DCR_MASK_RATE) == (DCR_RST_RATE & ~DCR_MASK_RATE) &&
    (second_loop_feedback_config & ~DCR_MASK_LOOP_FB) == 8'h00)
    else $error("unused bits changed");

  // ----------------------------------------------------------------
  // hold, write and readback checks
  // ----------------------------------------------------------------
  // fields only move on a write to their own register
  fb_hold_a: assert property (
    !(reg_wr && reg_addr == DCR_OFF_LOOP_FB) |=> $stable(second_loop_digital_feedback))
    else $error("feedback bit moved without a write");

  family_hold_a: assert property (
    !(reg_wr && reg_addr == DCR_OFF_FAMILY) |=> $stable(digital_rate_family_select))
    else $error("family register moved without a write");

  rate_hold_a: assert property (
    !(reg_wr && reg_addr == DCR_OFF_RATE) |=> $stable(digital_rate_select))
    else $error("rate register moved without a write");

  // read data stands between reads
  rdata_hold_a: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");

  // rate codes land from the written byte
  rate_write_a: assert property (
    reg_wr && reg_addr == DCR_OFF_RATE |=>
      gen_two_rate_code == $past(reg_wdata[7:6]) &&
      gen_one_rate_code == $past(reg_wdata[5:4]))
    else $error("rate codes not written");

  // readback shows used fields with unused bits at reset level
  family_readback_a: assert property (
    reg_rd && reg_addr == DCR_OFF_FAMILY && !reg_wr |=>
      reg_rdata == {1'b0, gen_two_family_select, gen_one_family_select, 5'h14})
    else $error("family register readback wrong");

  rate_readback_a: assert property (
    reg_rd && reg_addr == DCR_OFF_RATE && !reg_wr |=>
      reg_rdata == {gen_two_rate_code, gen_one_rate_code, 4'h8})
    else $error("rate register readback wrong");

  // ----------------------------------------------------------------
  // decoded rate spot checks
  // ----------------------------------------------------------------
  // settings held for a cycle, so the registered decode has caught up
  rate_sonet_base_a: assert property (
    gen_two_family_select && gen_two_rate_code == 2'h0 && $stable(digital_rate_family_select)
      && $stable(digital_rate_select) |=> gen_two_rate_khz == 15'h0608)
    else $error("sonet base rate wrong");

  rate_sdh_quad_a: assert property (
    !gen_two_family_select && gen_two_rate_code == 2'h2 && $stable(digital_rate_family_select)
      && $stable(digital_rate_select) |=> gen_two_rate_khz == 15'h2000)
    else $error("sdh quad rate wrong");

  rate_sonet_top_a: assert property (
    gen_one_family_select && gen_one_rate_code == 2'h3 && $stable(digital_rate_family_select)
      && $stable(digital_rate_select) |=> gen_one_rate_khz == 15'h3040)
    else $error("sonet top rate wrong");

  rate_sdh_double_a: assert property (
    !gen_one_family_select && gen_one_rate_code == 2'h1 && $stable(digital_rate_family_select)
      && $stable(digital_rate_select) |=> gen_one_rate_khz == 15'h1000)
    else $error("sdh double rate wrong");
endmodule
`default_nettype wire
